// ===== rtl/dual_timer_pkg.sv
// package: register map, field positions, reset values, divider figures
package dual_timer_pkg;
   localparam logic [15:0] UNIT_A_MODE_CONTROL_ADDR = 16'hff70;
   localparam logic [15:0] UNIT_A_CLOCK_SELECT_ADDR = 16'hff71;
   localparam logic [15:0] UNIT_B_MODE_CONTROL_ADDR = 16'hff74;
   localparam logic [15:0] UNIT_B_CLOCK_SELECT_ADDR = 16'hff75;
   localparam logic [15:0] UNIT_A_COMPARE_ADDR = 16'hff72;
   localparam logic [15:0] UNIT_A_COUNTER_ADDR = 16'hff73;
   localparam logic [15:0] UNIT_B_COMPARE_ADDR = 16'hff76;
   localparam logic [15:0] UNIT_B_COUNTER_ADDR = 16'hff77;
   localparam int OUTPUT_GATE_BIT = 0;
   localparam int LEVEL_OR_TOGGLE_BIT = 1;
   localparam int FORCE_CLEAR_BIT = 2;
   localparam int FORCE_SET_BIT = 3;
   localparam int PWM_MODE_BIT = 6;
   localparam int UNIT_RUN_BIT = 7;
   localparam logic [7:0] MODE_WRITE_MASK = 8'hcf;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [2:0] SEL_EXT_FALL = 3'h0;
   localparam logic [2:0] SEL_EXT_RISE = 3'h1;
   // divider exponents for codes 3..7
   localparam int DIV_EXP_3 = 1;
   localparam int DIV_EXP_4 = 3;
   localparam int DIV_EXP_5 = 5;
   localparam int DIV_EXP_6 = 7;
   localparam int DIV_EXP_A7 = 9;
   localparam int DIV_EXP_B7 = 12;
   localparam int PRESCALE_WIDTH = 12;
endpackage

// ===== rtl/main_prescaler.sv
// free-running prescaler giving one-cycle tick enables
`timescale 1ns/1ps
module main_prescaler #(
   parameter int WIDTH = dual_timer_pkg::PRESCALE_WIDTH
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   output logic [WIDTH-1:0] tick_out
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   initial
   begin
      if (WIDTH < dual_timer_pkg::DIV_EXP_B7)
         $error("prescaler too narrow");
   end

   // tick k pulses once every 2^(k+1) cycles
   always_comb
   begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         count_reg <= '0;
      else
         count_reg <= count_next;
   end

   genvar k;
   generate
      for (k = 0; k < WIDTH; k++)
      begin : g_tick
         assign tick_out[k] = (count_reg[k:0] == {(k+1){1'b1}});
      end
   endgenerate
endmodule

// ===== rtl/timer_unit.sv
// one 8-bit timer/event counter: counter, compare, output flip-flop
`timescale 1ns/1ps
module timer_unit #(
   parameter int LAST_EXP = dual_timer_pkg::DIV_EXP_A7
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [11:0] tick_in,
   input wire logic event_in,
   input wire logic [7:0] mode_in,
   input wire logic [2:0] clock_select_in,
   input wire logic [7:0] compare_in,
   input wire logic force_set_in,
   input wire logic force_clear_in,
   output logic [7:0] counter_out,
   output logic match_irq_out,
   output logic wave_out,
   output logic wave_oe_out
);
   logic [1:0] sync_reg;
   logic [1:0] sync_next;
   logic prev_reg;
   logic prev_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic irq_reg;
   logic irq_next;
   logic ff_reg;
   logic ff_next;
   logic wave_reg;
   logic wave_next;
   logic count_en;
   logic run;
   logic pwm;
   logic ext_sel;
   logic active_level;
   logic match;

   initial
   begin
      if (LAST_EXP < 1 || LAST_EXP > 12)
         $error("bad divider exponent");
   end

   assign run = mode_in[dual_timer_pkg::UNIT_RUN_BIT];
   assign pwm = mode_in[dual_timer_pkg::PWM_MODE_BIT];
   assign ext_sel = (clock_select_in == dual_timer_pkg::SEL_EXT_FALL) ||
                    (clock_select_in == dual_timer_pkg::SEL_EXT_RISE);
   assign match = (count_reg == compare_in);

   // count clock selection; pin edges seen after two flops
   always_comb
   begin
      sync_next = {sync_reg[0], event_in};
      prev_next = sync_reg[1];
      case (clock_select_in)
         3'h0: count_en = prev_reg & ~sync_reg[1];
         3'h1: count_en = ~prev_reg & sync_reg[1];
         3'h2: count_en = 1'b1;
         3'h3: count_en = tick_in[dual_timer_pkg::DIV_EXP_3-1];
         3'h4: count_en = tick_in[dual_timer_pkg::DIV_EXP_4-1];
         3'h5: count_en = tick_in[dual_timer_pkg::DIV_EXP_5-1];
         3'h6: count_en = tick_in[dual_timer_pkg::DIV_EXP_6-1];
         default: count_en = tick_in[LAST_EXP-1];
      endcase
   end

   // counter, match request and output flip-flop
   always_comb
   begin
      count_next = count_reg;
      irq_next = 1'b0;
      ff_next = ff_reg;
      if (!run)
         count_next = dual_timer_pkg::COUNTER_RESET;
      else if (count_en)
      begin
         if (!pwm && match)
         begin
            count_next = 8'h00;
            irq_next = 1'b1;
            if (mode_in[dual_timer_pkg::LEVEL_OR_TOGGLE_BIT])
               ff_next = ~ff_reg;
         end
         else
         begin
            count_next = count_reg + 8'h01; // wraps ff to 00
            irq_next = match;
         end
      end
      // force wins over toggle; 11 is never written
      if (force_set_in)
         ff_next = 1'b1;
      else if (force_clear_in)
         ff_next = 1'b0;
   end

   // pwm: active while count below compare, 8-bit duty
   always_comb
   begin
      active_level = ~mode_in[dual_timer_pkg::LEVEL_OR_TOGGLE_BIT];
      if (pwm)
         wave_next = (run && count_reg < compare_in) ? active_level
                     : ~active_level;
      else
         wave_next = ff_reg;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         sync_reg <= 2'h0;
         prev_reg <= 1'b0;
         count_reg <= dual_timer_pkg::COUNTER_RESET;
         irq_reg <= 1'b0;
         ff_reg <= 1'b0;
         wave_reg <= 1'b0;
      end
      else
      begin
         sync_reg <= sync_next;
         prev_reg <= prev_next;
         count_reg <= count_next;
         irq_reg <= irq_next;
         ff_reg <= ff_next;
         wave_reg <= wave_next;
      end
   end

   assign counter_out = count_reg;
   assign match_irq_out = irq_reg;
   assign wave_out = wave_reg;
   // external clocking makes the output unusable
   assign wave_oe_out = mode_in[dual_timer_pkg::OUTPUT_GATE_BIT] &
                        ~ext_sel;

   a_match_clears: assert property (
      @(posedge clk_in) disable iff (srst_in)
      run && !pwm && count_en && match |=> count_reg == 8'h00 && irq_reg)
      else $error("match did not clear counter");
   a_stop_zeroes: assert property (
      @(posedge clk_in) disable iff (srst_in)
      !run |=> count_reg == 8'h00)
      else $error("stopped counter not zero");
   a_force_set: assert property (
      @(posedge clk_in) disable iff (srst_in)
      force_set_in |=> ff_reg)
      else $error("force set ignored");
   a_force_clear: assert property (
      @(posedge clk_in) disable iff (srst_in)
      force_clear_in && !force_set_in |=> !ff_reg)
      else $error("force clear ignored");
   a_gate_external: assert property (
      @(posedge clk_in) disable iff (srst_in)
      ext_sel |-> !wave_oe_out)
      else $error("output on external clock");
   a_irq_cause: assert property (
      @(posedge clk_in) disable iff (srst_in)
      irq_reg |-> $past(match) && $past(count_en) && $past(run))
      else $error("spurious match request");
   a_main_counts: assert property (
      @(posedge clk_in) disable iff (srst_in)
      run && clock_select_in == 3'h2 && !match && $stable(mode_in)
      |=> count_reg == $past(count_reg) + 8'h01)
      else $error("main clock count missed");
   c_match: cover property (@(posedge clk_in) irq_reg && !pwm);
   c_pwm_wrap: cover property (@(posedge clk_in)
      pwm && count_reg == 8'hff ##1 count_reg == 8'h00);
   c_toggle: cover property (@(posedge clk_in) $changed(ff_reg));
endmodule

// ===== rtl/dual_timer_top.sv
// dual 8-bit timer/event counter with byte and bit register access
// Overview of operation
// - match of counter and compare raises request
// - compare holds any byte, resets zero
// - counter counts, byte readable, resets zero
// - unit a clock codes: edges, main, prescaled
// - unit b code 7 divides by 4096
// - external clocking disables timer output
// - mode bit 0 gates output pin
// - bit 1: pwm level or toggle enable
// - bits 3:2 force flip-flop, 11 forbidden
// - bit 6: clear-start or free pwm
// - run bit zero stops and clears counter
// - mode register byte or bit writable
// - pwm duty has eight-bit resolution
// - clear-start match restarts counter, period compare plus one
// - run bit one starts counting
// - force bits read back as zero
`timescale 1ns/1ps
module dual_timer_top (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [15:0] addr_in,
   input wire logic wr_in,
   input wire logic bit_wr_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   input wire logic unit_a_event_input_in,
   input wire logic unit_b_event_input_in,
   output logic unit_a_wave_out,
   output logic unit_a_wave_oe_out,
   output logic unit_b_wave_out,
   output logic unit_b_wave_oe_out,
   output logic unit_a_match_irq_out,
   output logic unit_b_match_irq_out
);
   logic [7:0] mode_reg [2];
   logic [7:0] mode_next [2];
   logic [2:0] csel_reg [2];
   logic [2:0] csel_next [2];
   logic [7:0] cmp_reg [2];
   logic [7:0] cmp_next [2];
   logic [1:0] fset_reg;
   logic [1:0] fset_next;
   logic [1:0] fclr_reg;
   logic [1:0] fclr_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] counter [2];
   logic [1:0] irq;
   logic [1:0] wave;
   logic [1:0] wave_oe;
   logic [1:0] events;
   logic [11:0] tick;
   logic [15:0] mode_addr [2];
   logic [15:0] csel_addr [2];
   logic [15:0] cmp_addr [2];

   // all checks below sample on the one clock and sleep in reset
   default clocking main_cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   assign mode_addr[0] = dual_timer_pkg::UNIT_A_MODE_CONTROL_ADDR;
   assign mode_addr[1] = dual_timer_pkg::UNIT_B_MODE_CONTROL_ADDR;
   assign csel_addr[0] = dual_timer_pkg::UNIT_A_CLOCK_SELECT_ADDR;
   assign csel_addr[1] = dual_timer_pkg::UNIT_B_CLOCK_SELECT_ADDR;
   assign cmp_addr[0] = dual_timer_pkg::UNIT_A_COMPARE_ADDR;
   assign cmp_addr[1] = dual_timer_pkg::UNIT_B_COMPARE_ADDR;
   assign events = {unit_b_event_input_in, unit_a_event_input_in};

   main_prescaler #(
      .WIDTH(dual_timer_pkg::PRESCALE_WIDTH)
   ) u_prescaler (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .tick_out(tick)
   );

   genvar u;
   generate
      for (u = 0; u < 2; u++)
      begin : g_unit
         // register writes for one unit
         always_comb
         begin
            mode_next[u] = mode_reg[u];
            csel_next[u] = csel_reg[u];
            cmp_next[u] = cmp_reg[u];
            fset_next[u] = 1'b0;
            fclr_next[u] = 1'b0;
            if (wr_in && addr_in == mode_addr[u])
            begin
               // force bits are triggers, never stored
               mode_next[u] = wdata_in & dual_timer_pkg::MODE_WRITE_MASK
                              & 8'hf3;
               fset_next[u] = wdata_in[dual_timer_pkg::FORCE_SET_BIT];
               fclr_next[u] = wdata_in[dual_timer_pkg::FORCE_CLEAR_BIT];
            end
            else if (bit_wr_in && addr_in == mode_addr[u])
            begin
               // single-bit write; reserved bits stay zero
               if (bit_sel_in == 3'h3)
                  fset_next[u] = wdata_in[0];
               else if (bit_sel_in == 3'h2)
                  fclr_next[u] = wdata_in[0];
               else if (dual_timer_pkg::MODE_WRITE_MASK[bit_sel_in])
                  mode_next[u][bit_sel_in] = wdata_in[0];
            end
            // upper bits dropped; software keeps them zero
            if (wr_in && addr_in == csel_addr[u])
               csel_next[u] = wdata_in[2:0];
            if (wr_in && addr_in == cmp_addr[u])
               cmp_next[u] = wdata_in;
         end

         always_ff @(posedge clk_in)
         begin
            if (srst_in)
            begin
               mode_reg[u] <= dual_timer_pkg::MODE_RESET;
               csel_reg[u] <= dual_timer_pkg::CLOCK_SELECT_RESET[2:0];
               cmp_reg[u] <= dual_timer_pkg::COMPARE_RESET;
               fset_reg[u] <= 1'b0;
               fclr_reg[u] <= 1'b0;
            end
            else
            begin
               mode_reg[u] <= mode_next[u];
               csel_reg[u] <= csel_next[u];
               cmp_reg[u] <= cmp_next[u];
               fset_reg[u] <= fset_next[u];
               fclr_reg[u] <= fclr_next[u];
            end
         end

         timer_unit #(
            .LAST_EXP(u == 0 ? dual_timer_pkg::DIV_EXP_A7
                             : dual_timer_pkg::DIV_EXP_B7)
         ) u_timer (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .tick_in(tick),
            .event_in(events[u]),
            .mode_in(mode_reg[u]),
            .clock_select_in(csel_reg[u]),
            .compare_in(cmp_reg[u]),
            .force_set_in(fset_reg[u]),
            .force_clear_in(fclr_reg[u]),
            .counter_out(counter[u]),
            .match_irq_out(irq[u]),
            .wave_out(wave[u]),
            .wave_oe_out(wave_oe[u])
         );
      end
   endgenerate

   // read mux, registered; unmapped reads give zero
   always_comb
   begin
      case (addr_in)
         dual_timer_pkg::UNIT_A_MODE_CONTROL_ADDR: rdata_next = mode_reg[0];
         dual_timer_pkg::UNIT_B_MODE_CONTROL_ADDR: rdata_next = mode_reg[1];
         dual_timer_pkg::UNIT_A_CLOCK_SELECT_ADDR:
            rdata_next = {5'h00, csel_reg[0]};
         dual_timer_pkg::UNIT_B_CLOCK_SELECT_ADDR:
            rdata_next = {5'h00, csel_reg[1]};
         dual_timer_pkg::UNIT_A_COMPARE_ADDR: rdata_next = cmp_reg[0];
         dual_timer_pkg::UNIT_B_COMPARE_ADDR: rdata_next = cmp_reg[1];
         dual_timer_pkg::UNIT_A_COUNTER_ADDR: rdata_next = counter[0];
         dual_timer_pkg::UNIT_B_COUNTER_ADDR: rdata_next = counter[1];
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end

   assign rdata_out = rdata_reg;
   assign unit_a_wave_out = wave[0];
   assign unit_b_wave_out = wave[1];
   assign unit_a_wave_oe_out = wave_oe[0];
   assign unit_b_wave_oe_out = wave_oe[1];
   assign unit_a_match_irq_out = irq[0];
   assign unit_b_match_irq_out = irq[1];

   a_force_reads_zero: assert property (
      @(posedge clk_in) disable iff (srst_in)
      (mode_reg[0][3:2] == 2'h0) && (mode_reg[1][3:2] == 2'h0))
      else $error("force bits stored");
   a_compare_write: assert property (
      @(posedge clk_in) disable iff (srst_in)
      wr_in && addr_in == dual_timer_pkg::UNIT_A_COMPARE_ADDR
      |=> cmp_reg[0] == $past(wdata_in))
      else $error("compare write lost");
   c_pwm_run: cover property (@(posedge clk_in)
      mode_reg[0][7] && mode_reg[0][6] && unit_a_wave_oe_out);

   // byte writes: bits 5:4 and the force triggers are never stored
   a_mode_byte_a: assert property (
      wr_in && addr_in == mode_addr[0]
      |=> mode_reg[0] == ($past(wdata_in) & 8'hc3))
      else $error("mode a byte write");

   a_mode_byte_b: assert property (
      wr_in && addr_in == mode_addr[1]
      |=> mode_reg[1] == ($past(wdata_in) & 8'hc3))
      else $error("mode b byte write");

   // bit writes other than to bits 5:4 change one stored bit or fire one trigger
   a_mode_bit_a: assert property (
      bit_wr_in && !wr_in && addr_in == mode_addr[0] &&
      bit_sel_in inside {3'h0, 3'h1, 3'h6, 3'h7}
      |=> mode_reg[0][$past(bit_sel_in)] == $past(wdata_in[0]))
      else $error("mode a bit write");

   a_clear_bit_a: assert property (
      bit_wr_in && !wr_in && addr_in == mode_addr[0] && bit_sel_in == 3'h2
      |=> fclr_reg[0] == $past(wdata_in[0]))
      else $error("force clear trigger");

   a_set_byte_a: assert property (
      wr_in && addr_in == mode_addr[0] && wdata_in[3]
      |=> fset_reg[0])
      else $error("force set trigger");

   // clock select keeps the three code bits only
   a_csel_write_a: assert property (
      wr_in && addr_in == csel_addr[0]
      |=> csel_reg[0] == $past(wdata_in[2:0]))
      else $error("clock select a write");

   a_csel_write_b: assert property (
      wr_in && addr_in == csel_addr[1]
      |=> csel_reg[1] == $past(wdata_in[2:0]))
      else $error("clock select b write");

   a_compare_write_b: assert property (
      wr_in && addr_in == cmp_addr[1]
      |=> cmp_reg[1] == $past(wdata_in))
      else $error("compare b write");

   // counters are read-only; a write there must not leak elsewhere
   a_counter_ro_a: assert property (
      wr_in && addr_in == dual_timer_pkg::UNIT_A_COUNTER_ADDR
      |=> $stable(cmp_reg[0]) && $stable(mode_reg[0]))
      else $error("counter a write leaked");

   a_counter_ro_b: assert property (
      wr_in && addr_in == dual_timer_pkg::UNIT_B_COUNTER_ADDR
      |=> $stable(cmp_reg[1]) && $stable(mode_reg[1]))
      else $error("counter b write leaked");

   // read data shows the register one cycle after its address
   a_read_count_a: assert property (
      addr_in == dual_timer_pkg::UNIT_A_COUNTER_ADDR
      |=> rdata_out == $past(counter[0]))
      else $error("counter a read");

   a_read_count_b: assert property (
      addr_in == dual_timer_pkg::UNIT_B_COUNTER_ADDR
      |=> rdata_out == $past(counter[1]))
      else $error("counter b read");

   a_read_cmp_a: assert property (
      addr_in == cmp_addr[0]
      |=> rdata_out == $past(cmp_reg[0]))
      else $error("compare a read");

   a_read_cmp_b: assert property (
      addr_in == cmp_addr[1]
      |=> rdata_out == $past(cmp_reg[1]))
      else $error("compare b read");

   a_read_mode_a: assert property (
      addr_in == mode_addr[0]
      |=> rdata_out == $past(mode_reg[0]) && rdata_out[3:2] == 2'h0)
      else $error("mode a read");

   a_read_mode_b: assert property (
      addr_in == mode_addr[1]
      |=> rdata_out == $past(mode_reg[1]) && rdata_out[3:2] == 2'h0)
      else $error("mode b read");

   a_read_csel_a: assert property (
      addr_in == csel_addr[0]
      |=> rdata_out == {5'h00, $past(csel_reg[0])})
      else $error("clock select a read");

   a_read_csel_b: assert property (
      addr_in == csel_addr[1]
      |=> rdata_out == {5'h00, $past(csel_reg[1])})
      else $error("clock select b read");

   // a match request lasts one cycle unless every clock counts
   a_irq_pulse_a: assert property (
      unit_a_match_irq_out && csel_reg[0] != 3'h2
      |=> !unit_a_match_irq_out)
      else $error("match a request too long");

   a_irq_pulse_b: assert property (
      unit_b_match_irq_out && csel_reg[1] != 3'h2
      |=> !unit_b_match_irq_out)
      else $error("match b request too long");

   // pin driven only when gated on and not counting external edges
   a_oe_gate_a: assert property (
      unit_a_wave_oe_out == (mode_reg[0][0] && csel_reg[0] > 3'h1))
      else $error("output a gate wrong");

   a_oe_gate_b: assert property (
      unit_b_wave_oe_out == (mode_reg[1][0] && csel_reg[1] > 3'h1))
      else $error("output b gate wrong");
endmodule

// ===== verification/event_pin_model.sv
// far-side model: external count pin and the unit a output pin
`timescale 1ns/1ps
module event_pin_model (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic [7:0] pulses_in,
   input wire logic [3:0] half_in,
   input wire logic wave_in,
   input wire logic wave_oe_in,
   output logic event_out,
   output logic busy_out,
   output logic pin_level_out
);
   // released pin floats to the board pull-up
   assign pin_level_out = wave_oe_in ? wave_in : 1'b1;

   // burst of pulses, idle low; half_in sets prompt or slow edges
   initial
   begin
      event_out = 1'b0;
      busy_out = 1'b0;
   end
   always
   begin
      @(posedge clk_in iff start_in);
      #1 busy_out = 1'b1;
      repeat (pulses_in)
      begin
         event_out = 1'b1;
         repeat (half_in + 1) @(posedge clk_in);
         #1 event_out = 1'b0;
         repeat (half_in + 1) @(posedge clk_in);
         #1;
      end
      busy_out = 1'b0;
   end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the dual timer/event counter
`timescale 1ns/1ps
module testbench;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] addr_in = 16'h0000;
   logic wr_in = 1'b0;
   logic bit_wr_in = 1'b0;
   logic [2:0] bit_sel_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic [7:0] rdata_out;
   logic ev, wa, wa_oe, wb, wb_oe, ia, ib, ev_busy, pin_a;
   logic ev_start = 1'b0;
   logic [7:0] ev_count = 8'h00;
   logic [3:0] ev_half = 4'h0;
   int fails = 0;
   int total_checks = 0;

   dual_timer_top dut (.clk_in(clk_in), .srst_in(srst_in),
      .addr_in(addr_in), .wr_in(wr_in), .bit_wr_in(bit_wr_in),
      .bit_sel_in(bit_sel_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
      .unit_a_event_input_in(ev), .unit_b_event_input_in(ev),
      .unit_a_wave_out(wa), .unit_a_wave_oe_out(wa_oe),
      .unit_b_wave_out(wb), .unit_b_wave_oe_out(wb_oe),
      .unit_a_match_irq_out(ia), .unit_b_match_irq_out(ib));

   event_pin_model far (.clk_in(clk_in), .start_in(ev_start),
      .pulses_in(ev_count), .half_in(ev_half), .wave_in(wa),
      .wave_oe_in(wa_oe), .event_out(ev), .busy_out(ev_busy),
      .pin_level_out(pin_a));

   // 250 MHz clock
   always #2 clk_in = ~clk_in;

   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // register address: unit base plus offset
   function automatic logic [15:0] ra(input int u, input int o);
      logic [15:0] b;
      b = u ? dual_timer_pkg::UNIT_B_MODE_CONTROL_ADDR
            : dual_timer_pkg::UNIT_A_MODE_CONTROL_ADDR;
      return b + 16'(o);
   endfunction

   // count clock period in main clocks
   function automatic int div_of(input int u, input int c);
      case (c)
         2: return 1;
         3: return 2;
         4: return 8;
         5: return 32;
         6: return 128;
         default: return u ? 4096 : 512;
      endcase
   endfunction

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1 addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      @(posedge clk_in);
      #1 wr_in = 1'b0;
   endtask

   task bwr(input logic [15:0] a, input logic [2:0] s, input logic v);
      @(posedge clk_in);
      #1 addr_in = a;
      bit_sel_in = s;
      wdata_in = {7'h00, v};
      bit_wr_in = 1'b1;
      @(posedge clk_in);
      #1 bit_wr_in = 1'b0;
   endtask

   // read data is registered: one edge after the address
   task rdreg(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #1 addr_in = a;
      @(posedge clk_in);
      #1 d = rdata_out;
   endtask

   task wait_irq(input int u, input int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(posedge clk_in);
         #1;
         if ((u ? ib : ia) === 1'b1)
            return;
      end
      fails++;
      $display("ERROR %0t match request missing", $time);
      close_out();
   endtask

   task skip(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // main sequence
   initial
   begin
      int u, c, k, lv, h, i;
      logic [7:0] d, e;
      logic w0;
      time t0;
      void'($urandom(32'h37c7a80a));
      skip(5);
      srst_in = 1'b0;
      // reset values, one unmapped address after the map
      for (i = 0; i < 9; i++)
      begin
         rdreg(16'hff70 + 16'(i), d);
         check(d, 16'h0000);
      end
      for (u = 0; u < 2; u++)
      begin
         e = 8'($urandom);
         wr(ra(u, 2), e);
         wr(ra(u, 3), ~e);
         rdreg(ra(u, 2), d);
         check(d, e);
         rdreg(ra(u, 3), d);
         check(d, 16'h0000);
      end
      // clear-and-start periods over every main-clock code
      for (u = 0; u < 2; u++)
         for (c = 2; c < 8; c++)
            for (k = 0; k < 3; k++)
               if (c == 2 || k == 0)
               begin
                  d = (c != 2) ? 8'h01 : (k == 0) ? 8'h00 :
                     (k == 1) ? 8'hff : 8'($urandom_range(2, 60));
                  wr(ra(u, 1), 8'(c));
                  wr(ra(u, 2), d);
                  wr(ra(u, 0), 8'h80);
                  wait_irq(u, 20000);
                  t0 = $time;
                  wait_irq(u, 20000);
                  check(16'(($time - t0) / 4),
                     16'((d + 1) * div_of(u, c)));
                  wr(ra(u, 0), 8'h00);
                  rdreg(ra(u, 3), d);
                  check(d, 16'h0000);
               end
      // forced flip-flop, gate, bit access
      wr(ra(0, 1), 8'h02);
      wr(ra(0, 0), 8'h09);
      skip(3);
      check(wa, 1'b1);
      check(wa_oe, 1'b1);
      rdreg(ra(0, 0), d);
      check(d, 16'h0001);
      bwr(ra(0, 0), 3'h2, 1'b1);
      skip(3);
      check(wa, 1'b0);
      bwr(ra(0, 0), 3'h0, 1'b0);
      skip(1);
      check(wa_oe, 1'b0);
      check(pin_a, 1'b1);
      bwr(ra(0, 0), 3'h7, 1'b1);
      rdreg(ra(0, 0), d);
      check(d, 16'h0080);
      // toggle enabled versus held output
      wr(ra(0, 2), 8'h04);
      for (k = 0; k < 2; k++)
      begin
         wr(ra(0, 0), 8'h00);
         wr(ra(0, 0), k ? 8'h83 : 8'h81);
         wait_irq(0, 100);
         skip(2);
         w0 = wa;
         wait_irq(0, 100);
         skip(2);
         if (k)
            w0 = ~w0;
         check(wa, w0);
      end
      wr(ra(0, 0), 8'h00);
      // pwm duty over one full 256-count frame, both levels
      for (u = 0; u < 2; u++)
         for (lv = 0; lv < 2; lv++)
            for (k = 0; k < 3; k++)
            begin
               d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff :
                  8'($urandom_range(1, 254));
               wr(ra(u, 1), 8'h02);
               wr(ra(u, 2), d);
               wr(ra(u, 0), lv ? 8'hc3 : 8'hc1);
               skip(8);
               h = 0;
               for (i = 0; i < 256; i++)
               begin
                  skip(1);
                  h += ((u ? wb : wa) === 1'b1) ? 1 : 0;
               end
               check(16'(h), 16'(lv ? 256 - d : d));
               wr(ra(u, 0), 8'h00);
            end
      // external edges, fast then slow pulses
      for (k = 0; k < 2; k++)
      begin
         wr(ra(0, 1), 8'(k));
         wr(ra(1, 1), 8'(1 - k));
         wr(ra(0, 2), 8'hff);
         wr(ra(1, 2), 8'hff);
         wr(ra(0, 0), 8'h81);
         wr(ra(1, 0), 8'h81);
         ev_count = 8'($urandom_range(1, 40));
         ev_half = k ? 4'h4 : 4'h1;
         ev_start = 1'b1;
         // held two edges so busy is up before it is polled
         skip(2);
         ev_start = 1'b0;
         for (i = 0; i < 2000 && ev_busy !== 1'b0; i++)
            skip(1);
         if (i == 2000)
         begin
            fails++;
            $display("ERROR %0t event burst hung", $time);
            close_out();
         end
         skip(4);
         check(wa_oe, 1'b0);
         check(wb_oe, 1'b0);
         for (u = 0; u < 2; u++)
         begin
            rdreg(ra(u, 3), d);
            check(d, ev_count);
            wr(ra(u, 0), 8'h00);
         end
      end
      close_out();
   end
endmodule
